// ===== shared/qpc_pkg.sv
`default_nettype none
package qpc_pkg;

	localparam int WORD_W = 24;
	localparam int NCHAN = 4;
	localparam int NSLOT = 4;
	localparam int TAP_W = 8;
	localparam int SLOT_W = 9;
	localparam int CNT_W = 5;

	// frame length that qualifies a command
	localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;

	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_WAKE = 4'h1;
	localparam logic [3:0] OP_PROG_NV = 4'h2;
	localparam logic [3:0] OP_SAVE = 4'h3;
	localparam logic [3:0] OP_WR_TAP = 4'h4;
	localparam logic [3:0] OP_UP = 4'h7;
	localparam logic [3:0] OP_SLEEP = 4'h8;
	localparam logic [3:0] OP_POR = 4'h9;
	localparam logic [3:0] OP_RD_NV = 4'hA;
	localparam logic [3:0] OP_LOAD = 4'hB;
	localparam logic [3:0] OP_RD_TAP = 4'hC;
	localparam logic [3:0] OP_DOWN = 4'hF;

	localparam logic [TAP_W-1:0] TAP_TOP = 8'hFF;
	localparam logic [TAP_W-1:0] TAP_BOTTOM = 8'h00;

	// internal access cycle of the stored slots
	localparam int CLK_NS = 8;
	localparam int ACCESS_NS = 1000;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUSY_W = 8;
	localparam logic [BUSY_W-1:0] BUSY_CYC = BUSY_W'(ACCESS_CYC);

	// contents of every stored slot after reset: mid-scale, buffer off
	localparam logic [SLOT_W-1:0] SLOT_RST = 9'h080;
	localparam logic [6:0] RD_FILL = 7'h00;
	localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;

	typedef logic [TAP_W-1:0] qpc_tap_t;
	typedef logic [SLOT_W-1:0] qpc_slot_t;

	typedef struct packed {
		logic [3:0] opcode_field;
		logic [1:0] slot_select;
		logic [1:0] channel_select;
		logic [6:0] spare;
		logic buffer_select_bit;
		qpc_tap_t wiper;
	} qpc_cmd_s;

	typedef enum logic [1:0] {
		ST_RECALL = 2'b00,
		ST_SLEEP = 2'b01,
		ST_AWAKE = 2'b11
	} qpc_state_e;

endpackage
`default_nettype wire

// ===== logic/qpc_link.sv
`default_nettype none
module qpc_link
	import qpc_pkg::*;
(
	input wire logic sclk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic rd_pend,
	input wire logic [WORD_W-1:0] rd_word,
	output qpc_cmd_s word,
	output logic [CNT_W-1:0] bit_count,
	output logic sdo_o,
	output logic sdo_oe
);

	typedef struct packed {
		logic [WORD_W-1:0] shreg;
		logic [CNT_W-1:0] cnt;
	} qpc_link_s;

	qpc_link_s s;
	qpc_link_s next_s;
	logic started;
	logic neg_seen;
	logic out_bit;
	logic use_rd;
	logic [WORD_W-1:0] src;
	logic sdo_bit;

	// read data was parked by the core before this frame began
	always_ff @(negedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			use_rd <= 1'b0;
		end else begin
			use_rd <= rd_pend;
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	// the old word leaves while the new one enters
	assign src = (!started && use_rd) ? rd_word : s.shreg;

	always_comb begin
		next_s = s;
		if (!cs_n) begin
			next_s.shreg = {src[WORD_W-2:0], sdi};
			if (!started) begin
				next_s.cnt = CNT_ONE;
			end else if (s.cnt != CNT_MAX) begin
				next_s.cnt = s.cnt + CNT_ONE;
			end
		end
	end

	// shift register is kept across frames so chained parts see old words
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{shreg: WORD_RST, cnt: '0};
		end else begin
			s <= next_s;
		end
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			neg_seen <= 1'b0;
		end else begin
			neg_seen <= 1'b1;
		end
	end

	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			out_bit <= 1'b0;
		end else begin
			out_bit <= s.shreg[WORD_W-1];
		end
	end

	// first bit shows from the chip select edge, later ones per falling clock
	assign sdo_bit = neg_seen ? out_bit : src[WORD_W-1];
	assign sdo_o = 1'b0;
	assign sdo_oe = !cs_n && !sdo_bit;
	assign word = qpc_cmd_s'(s.shreg);
	assign bit_count = s.cnt;

endmodule
`default_nettype wire

// ===== logic/qpc_core.sv
`default_nettype none
module qpc_core
	import qpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic wp_n,
	output logic sdo_o,
	output logic sdo_oe,
	output logic rdy_o,
	output logic rdy_oe,
	output qpc_tap_t [NCHAN-1:0] wiper_position_reg,
	output logic [NCHAN-1:0] buffer_select_bit,
	output logic device_awake
);

	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic wp_s1;
		logic wp_s2;
		qpc_state_e st;
		qpc_tap_t [NCHAN-1:0] tap;
		logic [NCHAN-1:0] bufsel;
		qpc_slot_t [NCHAN-1:0][NSLOT-1:0] stored_setting_slot;
		logic [BUSY_W-1:0] busy_cnt;
		logic [WORD_W-1:0] rd_word;
		logic rd_pend;
	} qpc_core_s;

	qpc_core_s s;
	qpc_core_s next_s;
	qpc_cmd_s word;
	logic [CNT_W-1:0] bit_count;
	logic frame_end;
	logic frame_start;
	logic frame_ok;
	logic wp_ok;
	logic [1:0] ch;
	logic [1:0] sl;

	function automatic qpc_tap_t tap_step(input qpc_tap_t v,
			input logic up);
		qpc_tap_t r;
		r = v;
		if (up) begin
			if (v != TAP_TOP) begin
				r = v + 8'h01;
			end
		end else begin
			if (v != TAP_BOTTOM) begin
				r = v - 8'h01;
			end
		end
		return r;
	endfunction

	function automatic logic uses_access(input logic [3:0] op);
		logic r;
		r = 1'b0;
		case (op)
			OP_RD_TAP, OP_RD_NV, OP_PROG_NV, OP_LOAD, OP_SAVE: begin
				r = 1'b1;
			end
			default: begin
				r = 1'b0;
			end
		endcase
		return r;
	endfunction

	function automatic logic [WORD_W-1:0] read_reply(input qpc_cmd_s c,
			input qpc_slot_t v);
		read_reply = {c.opcode_field, c.slot_select, c.channel_select,
			RD_FILL, v};
	endfunction

	qpc_link u_link (
		.sclk(sclk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sdi(sdi),
		.rd_pend(s.rd_pend),
		.rd_word(s.rd_word),
		.word(word),
		.bit_count(bit_count),
		.sdo_o(sdo_o),
		.sdo_oe(sdo_oe)
	);

	// the link word is stable once chip select is high: sclk then rests
	assign frame_end = s.cs_s2 && !s.cs_s3;
	assign frame_start = !s.cs_s2 && s.cs_s3;
	assign frame_ok = frame_end && (bit_count == FRAME_BITS);
	assign wp_ok = s.wp_s2;
	assign ch = word.channel_select;
	assign sl = word.slot_select;

	always_comb begin
		next_s = s;
		next_s.cs_s1 = cs_n;
		next_s.cs_s2 = s.cs_s1;
		next_s.cs_s3 = s.cs_s2;
		next_s.wp_s1 = wp_n;
		next_s.wp_s2 = s.wp_s1;

		if (s.busy_cnt != '0) begin
			next_s.busy_cnt = s.busy_cnt - 8'h01;
		end

		// reply is consumed by the frame that follows the read
		if (frame_start) begin
			next_s.rd_pend = 1'b0;
		end

		case (s.st)
			ST_RECALL: begin
				for (int i = 0; i < NCHAN; i++) begin
					next_s.tap[i] = s.stored_setting_slot[i][0][TAP_W-1:0];
					next_s.bufsel[i] = s.stored_setting_slot[i][0][TAP_W];
				end
				next_s.st = ST_SLEEP;
			end

			ST_SLEEP: begin
				// wiper settings stay put while asleep
				if (frame_ok && word.opcode_field == OP_WAKE) begin
					next_s.st = ST_AWAKE;
				end
			end

			ST_AWAKE: begin
				if (frame_ok) begin
					if (uses_access(word.opcode_field)) begin
						next_s.busy_cnt = BUSY_CYC;
					end
					case (word.opcode_field)
						OP_NOP, OP_WAKE: begin
							next_s.st = ST_AWAKE;
						end

						OP_SLEEP: begin
							next_s.st = ST_SLEEP;
						end

						OP_POR: begin
							next_s.st = ST_RECALL;
						end

						OP_WR_TAP: begin
							// buffer bit deliberately untouched
							next_s.tap[ch] = word.wiper;
						end

						OP_UP: begin
							next_s.tap[ch] = tap_step(s.tap[ch], 1'b1);
						end

						OP_DOWN: begin
							next_s.tap[ch] = tap_step(s.tap[ch], 1'b0);
						end

						OP_RD_TAP: begin
							next_s.rd_word = read_reply(word,
								{s.bufsel[ch], s.tap[ch]});
							next_s.rd_pend = 1'b1;
						end

						OP_RD_NV: begin
							next_s.rd_word = read_reply(word,
								s.stored_setting_slot[ch][sl]);
							next_s.rd_pend = 1'b1;
						end

						OP_PROG_NV: begin
							if (wp_ok) begin
								next_s.stored_setting_slot[ch][sl] =
									{word.buffer_select_bit, word.wiper};
							end
						end

						OP_SAVE: begin
							if (wp_ok) begin
								next_s.stored_setting_slot[ch][sl] =
									{s.bufsel[ch], s.tap[ch]};
							end
						end

						OP_LOAD: begin
							// with the recall after OP_POR, the only path by which the buffer bit changes
							next_s.tap[ch] =
								s.stored_setting_slot[ch][sl][TAP_W-1:0];
							next_s.bufsel[ch] =
								s.stored_setting_slot[ch][sl][TAP_W];
						end

						default: begin
							next_s.st = ST_AWAKE;
						end
					endcase
				end
			end

			default: begin
				next_s.st = ST_RECALL;
			end
		endcase
	end

	// slots come up at a fixed value: rst_n stands for first power-up only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s.cs_s1 <= 1'b1;
			s.cs_s2 <= 1'b1;
			s.cs_s3 <= 1'b1;
			s.wp_s1 <= 1'b1;
			s.wp_s2 <= 1'b1;
			s.st <= ST_RECALL;
			s.tap <= '0;
			s.bufsel <= '0;
			s.stored_setting_slot <= {(NCHAN * NSLOT){SLOT_RST}};
			s.busy_cnt <= '0;
			s.rd_word <= WORD_RST;
			s.rd_pend <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// busy pulls the line low only while chip select rests high
	assign rdy_o = 1'b0;
	assign rdy_oe = (s.busy_cnt != '0) && s.cs_s2;

	assign wiper_position_reg = s.tap;
	assign buffer_select_bit = s.bufsel;
	assign device_awake = (s.st == ST_AWAKE);

endmodule
`default_nettype wire

// ===== dv/qpc_core_chk.sv
`default_nettype none
module qpc_core_chk
	import qpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic rdy_o,
	input wire logic rdy_oe,
	input wire qpc_tap_t [NCHAN-1:0] wiper_position_reg,
	input wire logic [NCHAN-1:0] buffer_select_bit,
	input wire logic device_awake
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// length of the present busy stretch
	logic [7:0] busy_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			busy_cnt <= 8'h00;
		else if (rdy_oe)
			busy_cnt <= busy_cnt + 8'h01;
		else
			busy_cnt <= 8'h00;
	end
	a_sdo_idle: assert property (cs_n |-> !sdo_oe)
		else $error("sdo driven while deselected");
	a_rdy_release: assert property (
		$fell(cs_n) |-> ##[1:4] !rdy_oe)
		else $error("ready not released after select");
	a_busy_max: assert property (busy_cnt <= 8'h7D)
		else $error("busy longer than access cycle");
	a_sleep_hold: assert property (
		!device_awake [*3] |=>
		$stable({wiper_position_reg, buffer_select_bit}))
		else $error("setting changed while asleep");
	a_tap_framed: assert property (
		$changed(wiper_position_reg) && $past(device_awake)
		|-> cs_n && $past(cs_n, 2))
		else $error("tap changed inside a frame");
	a_bufsel_load: assert property (
		$changed(buffer_select_bit) |-> rdy_oe || !$past(device_awake))
		else $error("buffer bit changed without load");
	a_busy_cause: assert property (
		$rose(rdy_oe) |-> cs_n && $past(cs_n, 2) && device_awake)
		else $error("busy raised without command");
	a_pins_open: assert property (!rdy_o && !sdo_o)
		else $error("open drain pin driven high");
endmodule
`default_nettype wire

// ===== dv/qpc_host.sv
`default_nettype none
module qpc_host (
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// clock only inside frames, msb first
	task automatic frame(input logic [23:0] w, input int n,
		output logic [23:0] r);
		r = 24'h000000;
		#3 cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi <= w[23 - i];
			#40 sclk <= 1'b1;
			r = {r[22:0], sdo};
			#40 sclk <= 1'b0;
		end
		#40 cs_n <= 1'b1;
		// stale data would hide a sampling slip
		sdi <= ~sdi;
	endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
module tb
	import qpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, wp_n = 1'b1, bz;
	logic sclk, cs_n, sdi, sdo_o, sdo_oe, rdy_o, rdy_oe, device_awake;
	qpc_tap_t [NCHAN-1:0] tap;
	logic [NCHAN-1:0] bsel;
	logic [23:0] r;
	int errors = 0, checked = 0;
	always #4 clk = ~clk;
	qpc_host i_qpc_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo(sdo_oe ? sdo_o : 1'b1));
	qpc_core i_qpc_core (.clk(clk), .rst_n(rst_n), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .wp_n(wp_n), .sdo_o(sdo_o),
		.sdo_oe(sdo_oe), .rdy_o(rdy_o), .rdy_oe(rdy_oe),
		.wiper_position_reg(tap), .buffer_select_bit(bsel),
		.device_awake(device_awake));
	task automatic chk(input logic [23:0] g, e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic final_report();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// every frame waits for ready, as any host may
	task automatic cmd(input logic [23:0] w, input int n = 24);
		@(posedge clk);
		i_qpc_host.frame(w, n, r);
		repeat (8) @(negedge clk);
		bz = rdy_oe;
		for (int i = 0; rdy_oe !== 1'b0; i++) begin
			if (i > 200) begin
				errors++;
				$display("MISMATCH t=%0t ready timeout", $time);
				final_report();
			end
			@(negedge clk);
		end
	endtask
	task automatic t_power();
		for (int c = 0; c < NCHAN; c++)
			chk(tap[c], 24'h80);
		chk(bsel, 24'h0);
		cmd(24'h410055);
		chk(tap[1], 24'h80);
		cmd(24'h100000);
		chk(device_awake, 24'h1);
		$display("test power done");
	endtask
	task automatic t_write();
		for (int c = 0; c < NCHAN; c++) begin
			cmd({OP_WR_TAP, 2'b00, 2'(c), 7'h00, 1'b1, 8'h10 + 8'(c)});
			chk(tap[c], 24'h10 + 24'(c));
		end
		chk(bsel, 24'h0);
		cmd(24'h400077, 23);
		chk(tap[0], 24'h10);
		cmd(24'h5000AA);
		chk(tap[0], 24'h10);
		cmd(24'h4000FE);
		cmd({OP_UP, 20'h00000});
		cmd({OP_UP, 20'h00000});
		chk(tap[0], 24'hFF);
		cmd(24'h400001);
		cmd({OP_DOWN, 20'h00000});
		cmd({OP_DOWN, 20'h00000});
		chk(tap[0], 24'h00);
		$display("test write done");
	endtask
	task automatic t_slots();
		for (int s = 0; s < NSLOT; s++) begin
			cmd({OP_PROG_NV, 2'(s), 2'b10, 7'h00, 1'b1, 8'hA0 + 8'(s)});
			chk(bz, 24'h1);
		end
		for (int s = 0; s < NSLOT; s++) begin
			cmd({OP_LOAD, 2'(s), 2'b10, 16'h0000});
			chk(tap[2], 24'hA0 + 24'(s));
			chk(bsel, 24'h4);
		end
		@(posedge clk) wp_n <= 1'b0;
		cmd(24'h260033);
		cmd(24'hB60000);
		chk(tap[2], 24'hA1);
		@(posedge clk) wp_n <= 1'b1;
		cmd(24'h42005C);
		cmd(24'h3E0000);
		cmd(24'h420000);
		cmd(24'hBE0000);
		chk(tap[2], 24'h5C);
		$display("test slots done");
	endtask
	task automatic t_read();
		cmd(24'hC20000);
		chk(bz, 24'h1);
		cmd(24'h0ABCDE);
		chk(r, 24'hC2015C);
		cmd(24'h000000);
		chk(r, 24'h0ABCDE);
		cmd(24'hAE0000);
		chk(bz, 24'h1);
		cmd(24'h000000);
		chk(r, 24'hAE015C);
		$display("test read done");
	endtask
	task automatic t_sleep();
		cmd(24'h800000);
		chk(device_awake, 24'h0);
		cmd(24'h430011);
		chk(tap[3], 24'h13);
		cmd(24'h100000);
		cmd(24'h900000);
		chk(device_awake, 24'h0);
		chk({tap[2], tap[0]}, 24'hA080);
		chk(bsel, 24'h4);
		$display("test sleep done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(negedge clk);
		t_power();
		t_write();
		t_slots();
		t_read();
		t_sleep();
		final_report();
	end
endmodule
bind qpc_core qpc_core_chk i_qpc_core_chk (.clk, .rst_n, .cs_n, .sdo_o,
	.sdo_oe, .rdy_o, .rdy_oe, .wiper_position_reg, .buffer_select_bit,
	.device_awake);
`default_nettype wire
